// ===== pkg/gcd_pkg.sv
package gcd_pkg;

  // register map, byte addresses on a 32-bit classic wishbone
  localparam int ADR_W = 4;
  localparam logic [ADR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADR_W-1:0] STATUS_OFS = 4'h4;

  // control fields
  localparam int CTRL_DIV_LSB = 0;
  localparam int CTRL_LEAF_LSB = 4;
  localparam int CTRL_HARD_BIT = 8;
  localparam int CTRL_STAGE_BIT = 9;
  localparam int CTRL_LCLR_BIT = 10;

  // status fields
  localparam int STAT_DIV_BIT = 0;
  localparam int STAT_LEAF_BIT = 1;
  localparam int STAT_GLOB_BIT = 2;
  localparam int STAT_EN_BIT = 3;
  localparam int STAT_CLR_BIT = 4;
  localparam int STAT_CNT_LSB = 8;
  localparam int STAT_LCNT_LSB = 12;

  // defaults: factor one, leaf factor one, synchronous enable, no staging, no leaf clear
  localparam logic [2:0] DIV_CODE_RST = 3'h0;
  localparam logic [1:0] LEAF_CODE_RST = 2'h0;
  localparam logic HARD_RST = 1'b0;
  localparam logic STAGE_RST = 1'b0;
  localparam logic LCLR_RST = 1'b0;

  // depth of the hard enable synchroniser and of the clear release synchroniser
  localparam int HARD_STAGES = 3;
  localparam int CLR_STAGES = 2;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } gcd_wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } gcd_wb_rsp_s;

endpackage : gcd_pkg

// ===== verilog/gcd_clock_divider.sv
// Functional notes
// - pass-through output is the input registered once on clk_sys, never divided, gated or cleared.
// - leaf divider divides by a static one, two, four or eight.
// - leaf factor resets to one, so leaf output follows the input.
// - gated output stays zero while clear is high.
// - enabled and not cleared, gated output is input divided by factor.
// - enable is registered to clk_sys, no output glitch.
// - clear asserts asynchronously and releases synchronously.
// - gated divide factor is one to eight, default one.
// - after clear release output rises on the first input edge.
// - while clear is asserted the output stops toggling.
// - odd factor above one: high phase one input cycle shorter than low.
// - enable low freezes output at its present level.
// - enable high again resumes the counter where it stopped.
// - factor eight, stopped two cycles after rise: stays high, falls two later.
// - clear forces a high output low at once, low stays low.
// - factor eight: rise at next edge after release, fall four later.
// - enable mode defaults to the synchronous single register.
// - hard mode puts a three-stage synchroniser on the enable.
// - staging setting, default off, registers the enable first.
// - leaf clear setting, default off, lets clear drive leaf clear.
//
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none

module gcd_clock_divider
  import gcd_pkg::*;
#(
  parameter logic [2:0] DIV_CODE_DEFAULT = DIV_CODE_RST,
  parameter logic [1:0] LEAF_CODE_DEFAULT = LEAF_CODE_RST
) (
  // system
  input wire logic clk_sys,
  input wire logic reset,
  // register bus
  input wire gcd_pkg::gcd_wb_req_s wb_req,
  output gcd_pkg::gcd_wb_rsp_s wb_rsp,
  // clock path; clk_in and enable sampled on clk_sys, clear_input acts asynchronously
  input wire logic clk_in,
  input wire logic enable,
  input wire logic clear_input,
  // divided and buffered clocks
  output logic global_out,
  output logic leaf_out,
  output logic div_out
);
  import gcd_pkg::*;

  // control register
  logic [2:0] div_code_reg;
  logic [1:0] leaf_code_reg;
  logic hard_reg;
  logic stage_reg;
  logic lclr_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;

  // clock path state
  logic in_q_reg;
  logic en_pre_reg;
  logic en_sync_reg;
  logic [HARD_STAGES-1:0] hs_reg;
  logic [CLR_STAGES-1:0] clr_sync_reg;
  logic [2:0] cnt_reg;
  logic [2:0] lcnt_reg;
  logic glob_reg;
  logic leaf_reg;
  logic div_reg;

  // decode and selection
  wire logic bus_req = wb_req.cyc && wb_req.stb && !ack_reg;
  wire logic hit_ctrl = wb_req.adr == CTRL_OFS;
  wire logic hit_stat = wb_req.adr == STATUS_OFS;
  wire logic wr_ctrl = bus_req && wb_req.we && hit_ctrl;
  wire logic in_rise = clk_in && !in_q_reg;
  wire logic en_in = stage_reg ? en_pre_reg : enable;
  wire logic en_eff = hard_reg ? hs_reg[HARD_STAGES-1] : en_sync_reg;
  wire logic clr_active = clr_sync_reg[CLR_STAGES-1];
  wire logic [3:0] factor = {1'b0, div_code_reg} + 4'h1;
  wire logic [3:0] half = factor >> 1;
  wire logic adv = in_rise && en_eff && !clr_active;
  wire logic [2:0] cnt_next = ({1'b0, cnt_reg} == factor - 4'h1) ? 3'h0 : cnt_reg + 3'h1;
  wire logic [3:0] lfactor = 4'h1 << leaf_code_reg;
  wire logic [3:0] lhalf = lfactor >> 1;
  // wrap on at-or-above so a count left by a larger leaf factor cannot run long
  wire logic [2:0] lcnt_next = ({1'b0, lcnt_reg} >= lfactor - 4'h1) ? 3'h0 : lcnt_reg + 3'h1;
  wire logic leaf_clear_n = !(lclr_reg && clear_input);

  logic [31:0] ctrl_view;
  logic [31:0] stat_view;
  logic [31:0] rdat_next;

  always_comb begin
    ctrl_view = 32'h0000_0000;
    ctrl_view[CTRL_DIV_LSB +: 3] = div_code_reg;
    ctrl_view[CTRL_LEAF_LSB +: 2] = leaf_code_reg;
    ctrl_view[CTRL_HARD_BIT] = hard_reg;
    ctrl_view[CTRL_STAGE_BIT] = stage_reg;
    ctrl_view[CTRL_LCLR_BIT] = lclr_reg;
    stat_view = 32'h0000_0000;
    stat_view[STAT_DIV_BIT] = div_reg;
    stat_view[STAT_LEAF_BIT] = leaf_reg;
    stat_view[STAT_GLOB_BIT] = glob_reg;
    stat_view[STAT_EN_BIT] = en_eff;
    stat_view[STAT_CLR_BIT] = clr_active;
    stat_view[STAT_CNT_LSB +: 3] = cnt_reg;
    stat_view[STAT_LCNT_LSB +: 3] = lcnt_reg;
  end

  assign rdat_next = hit_ctrl ? ctrl_view : (hit_stat ? stat_view : 32'h0000_0000);

  // wishbone slave: one wait state, unmapped reads zero and is still acked
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req;
      rdat_reg <= rdat_next;
    end
  end

  assign wb_rsp.ack = ack_reg;
  assign wb_rsp.dat = rdat_reg;

  // divide factors should only be changed while clear is held
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      div_code_reg <= DIV_CODE_DEFAULT;
      leaf_code_reg <= LEAF_CODE_DEFAULT;
      hard_reg <= HARD_RST;
      stage_reg <= STAGE_RST;
      lclr_reg <= LCLR_RST;
    end else if (wr_ctrl) begin
      if (wb_req.sel[0]) begin
        div_code_reg <= wb_req.dat[CTRL_DIV_LSB +: 3];
        leaf_code_reg <= wb_req.dat[CTRL_LEAF_LSB +: 2];
      end
      if (wb_req.sel[1]) begin
        hard_reg <= wb_req.dat[CTRL_HARD_BIT];
        stage_reg <= wb_req.dat[CTRL_STAGE_BIT];
        lclr_reg <= wb_req.dat[CTRL_LCLR_BIT];
      end
    end
  end

  // enable path and input sampling
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      in_q_reg <= 1'b0;
      en_pre_reg <= 1'b0;
      en_sync_reg <= 1'b0;
      hs_reg <= '0;
      glob_reg <= 1'b0;
    end else begin
      in_q_reg <= clk_in;
      en_pre_reg <= enable;
      en_sync_reg <= en_in;
      hs_reg <= {hs_reg[HARD_STAGES-2:0], en_in};
      glob_reg <= clk_in;
    end
  end

  // clear: set at once by the pin, released through two registers
  always_ff @(posedge clk_sys or posedge clear_input) begin
    if (clear_input) begin
      clr_sync_reg <= '1;
    end else if (reset) begin
      clr_sync_reg <= '1;
    end else begin
      clr_sync_reg <= {clr_sync_reg[CLR_STAGES-2:0], 1'b0};
    end
  end

  // gated divider; the counter and level freeze whenever enable is low and clear is inactive
  always_ff @(posedge clk_sys or posedge clear_input) begin
    if (clear_input) begin
      cnt_reg <= 3'h0;
      div_reg <= 1'b0;
    end else if (reset || clr_active) begin
      cnt_reg <= 3'h0;
      div_reg <= 1'b0;
    end else if (factor == 4'h1) begin
      if (en_eff) begin
        div_reg <= clk_in;
      end
    end else if (adv) begin
      div_reg <= ({1'b0, cnt_reg} < half);
      cnt_reg <= cnt_next;
    end
  end

  // leaf divider, free running apart from its optional clear
  always_ff @(posedge clk_sys or negedge leaf_clear_n) begin
    if (!leaf_clear_n) begin
      lcnt_reg <= 3'h0;
      leaf_reg <= 1'b0;
    end else if (reset) begin
      lcnt_reg <= 3'h0;
      leaf_reg <= 1'b0;
    end else if (lfactor == 4'h1) begin
      leaf_reg <= clk_in;
    end else if (in_rise) begin
      leaf_reg <= ({1'b0, lcnt_reg} < lhalf);
      lcnt_reg <= lcnt_next;
    end
  end

  assign global_out = glob_reg;
  assign leaf_out = leaf_reg;
  assign div_out = div_reg;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_release;
    $fell(clr_active) ##0 !clear_input;
  endsequence

  sequence s_first_edge;
    adv && cnt_reg == 3'h0 && factor > 4'h1;
  endsequence

  a_pass_follows: assert property (!$past(reset) |-> glob_reg == $past(clk_in))
    else $error("pass-through output does not follow input");

  a_leaf_unity: assert property (disable iff (reset || !leaf_clear_n)
      leaf_code_reg == 2'h0 && $stable(leaf_code_reg) |=> leaf_reg == $past(clk_in))
    else $error("leaf factor one does not pass input");

  a_clear_low: assert property (clear_input |-> !div_reg)
    else $error("gated output high during clear");

  a_freeze_hold: assert property (disable iff (reset || clear_input)
      !en_eff && !clr_active |=> $stable(div_reg) && $stable(cnt_reg))
    else $error("gated output moved while disabled");

  a_first_rise: assert property (disable iff (reset || clear_input)
      s_first_edge |=> div_reg)
    else $error("no rise on first edge after clear");

  a_half_fall: assert property (disable iff (reset || clear_input)
      adv && factor > 4'h1 && {1'b0, cnt_reg} == half |=> !div_reg)
    else $error("gated output high phase too long");

  a_high_phase: assert property (disable iff (reset || clear_input)
      adv && {1'b0, cnt_reg} < half |=> div_reg)
    else $error("gated output high phase too short");

  a_count_wrap: assert property (disable iff (reset || clear_input)
      adv && factor > 4'h1 && {1'b0, cnt_reg} == factor - 4'h1 |=> cnt_reg == 3'h0)
    else $error("divide counter misses wrap");

  a_hard_latency: assert property (disable iff (reset || clear_input)
      (hard_reg && $rose(en_in)) ##0 (en_in && hard_reg) [*3] |=> en_eff)
    else $error("hard enable latency too long");

  a_release_hold: assert property (disable iff (reset)
      s_release |-> cnt_reg == 3'h0 && !div_reg)
    else $error("counter not at zero on clear release");

  a_bus_ack: assert property (bus_req |=> ack_reg ##1 !ack_reg)
    else $error("bus access not acked in one cycle");

  sequence s_enable_up;
    !hard_reg && !stage_reg && enable;
  endsequence

  sequence s_hard_drop;
    (hard_reg && $fell(en_in)) ##0 (!en_in && hard_reg) [*3];
  endsequence

  a_clear_count: assert property (clr_active |=> cnt_reg == 3'h0 && !div_reg)
    else $error("divider ran while clear active");

  a_unity_copy: assert property (disable iff (reset || clear_input)
      factor == 4'h1 && en_eff && !clr_active |=> div_reg == $past(clk_in))
    else $error("factor one does not pass input");

  a_low_phase: assert property (disable iff (reset || clear_input)
      adv && factor > 4'h1 && {1'b0, cnt_reg} >= half |=> !div_reg)
    else $error("gated output high in low phase");

  a_count_step: assert property (disable iff (reset || clear_input)
      adv && factor > 4'h1 && {1'b0, cnt_reg} != factor - 4'h1
      |=> cnt_reg == $past(cnt_reg) + 3'h1)
    else $error("divide counter skipped a step");

  a_idle_count: assert property (disable iff (reset || clear_input)
      !adv |=> $stable(cnt_reg))
    else $error("divide counter moved without an input edge");

  a_stop_high: assert property (disable iff (reset || clear_input)
      div_reg && !en_eff && !clr_active |=> div_reg)
    else $error("high output dropped while disabled");

  a_eight_fall: assert property (disable iff (reset || clear_input)
      adv && factor == 4'h8 && cnt_reg == 3'h4 |=> !div_reg)
    else $error("factor eight high phase not four cycles");

  a_seven_fall: assert property (disable iff (reset || clear_input)
      adv && factor == 4'h7 && cnt_reg == 3'h3 |=> !div_reg)
    else $error("factor seven high phase not three cycles");

  a_clear_drop: assert property ($rose(clear_input) |-> !div_reg)
    else $error("clear did not drop output at once");

  a_leaf_high: assert property (disable iff (reset || !leaf_clear_n)
      in_rise && lfactor > 4'h1 && {1'b0, lcnt_reg} < lhalf |=> leaf_reg)
    else $error("leaf output low in high phase");

  a_leaf_low: assert property (disable iff (reset || !leaf_clear_n)
      in_rise && lfactor > 4'h1 && {1'b0, lcnt_reg} >= lhalf |=> !leaf_reg)
    else $error("leaf output high in low phase");

  a_leaf_wrap: assert property (disable iff (reset || !leaf_clear_n)
      in_rise && lfactor > 4'h1 && {1'b0, lcnt_reg} >= lfactor - 4'h1
      |=> lcnt_reg == 3'h0)
    else $error("leaf counter misses wrap");

  a_leaf_hold: assert property (disable iff (reset || !leaf_clear_n)
      !in_rise && lfactor > 4'h1 |=> $stable(leaf_reg) && $stable(lcnt_reg))
    else $error("leaf divider moved without an input edge");

  a_leaf_clear: assert property (lclr_reg && clear_input
      |-> !leaf_reg && lcnt_reg == 3'h0)
    else $error("leaf divider ran during leaf clear");

  a_hard_fall: assert property (disable iff (reset || clear_input)
      s_hard_drop |=> !en_eff)
    else $error("hard enable release latency too long");

  a_sync_enable: assert property (disable iff (reset || clear_input)
      s_enable_up ##1 !hard_reg |-> en_eff)
    else $error("synchronous enable latency wrong");

  a_ack_once: assert property (ack_reg |=> !ack_reg)
    else $error("ack held longer than one cycle");

  a_status_ro: assert property (bus_req && wb_req.we && !hit_ctrl
      |=> $stable(div_code_reg) && $stable(hard_reg) && $stable(lclr_reg))
    else $error("write outside control changed settings");

endmodule : gcd_clock_divider

`default_nettype wire

// ===== verification/gcd_fabric_model.sv
`timescale 1ns/10ps
`default_nettype none

module gcd_fabric_model (
  // system
  input wire logic clk_sys,
  // commands from the bench
  input wire logic en_cmd,
  input wire logic clr_cmd,
  // toward the block
  output logic clk_in = 1'b0,
  output logic enable = 1'b0,
  output logic clear_input = 1'b1
);
  // input clock runs free at half the system rate, so every input cycle is two sampled cycles
  // controls leave a register, as fabric logic would, never mid-cycle
  always @(posedge clk_sys) begin
    clk_in <= ~clk_in;
    enable <= en_cmd;
    clear_input <= clr_cmd;
  end
endmodule : gcd_fabric_model

`default_nettype wire

// ===== verification/gcd_clock_divider_tb.sv
`timescale 1ns/10ps
`default_nettype none

module gcd_clock_divider_tb;
  import gcd_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic en_cmd = 1'b1;
  logic clr_cmd = 1'b1;
  gcd_wb_req_s wb_req = '0;
  gcd_wb_rsp_s wb_rsp;
  logic clk_in, enable, clear_input, global_out, leaf_out, div_out, pd, pl, pc;
  logic [31:0] q;
  int errors = 0;
  int num_checks = 0;
  int hd, rd, rl, gm, n, k, t;
  // rows: ctrl word, div high cycles, div rises, leaf rises over 1680 cycles
  int rows [8][4] = '{'{'h00, 840, 840, 840}, '{'h11, 840, 420, 420}, '{'h22, 560, 280, 210},
    '{'h33, 840, 210, 105}, '{'h04, 672, 168, 840}, '{'h15, 840, 140, 420},
    '{'h26, 720, 120, 210}, '{'h37, 840, 105, 105}};

  gcd_fabric_model fab (.clk_sys(clk_sys), .en_cmd(en_cmd), .clr_cmd(clr_cmd), .clk_in(clk_in),
    .enable(enable), .clear_input(clear_input));
  gcd_clock_divider dut (.clk_sys(clk_sys), .reset(reset), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .clk_in(clk_in), .enable(enable), .clear_input(clear_input), .global_out(global_out),
    .leaf_out(leaf_out), .div_out(div_out));

  task print_verdict;
    if (errors == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("unexpected %s: expected %0h seen %0h", s, e, g);
      errors++;
    end
  endtask : chk

  // one classic cycle; the answer is taken at the edge that shows ack
  task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wb_req <= '{1'b1, 1'b1, we, a, 4'hF, d};
    do @(posedge clk_sys); while (wb_rsp.ack !== 1'b1);
    q = wb_rsp.dat;
    wb_req <= '0;
  endtask : wb

  task measure(input int w);
    @(posedge clk_sys);
    {hd, rd, rl, gm} = '0;
    {pd, pl, pc} = {div_out, leaf_out, clk_in};
    repeat (w) begin
      @(posedge clk_sys);
      hd += int'(div_out);
      rd += int'(div_out & ~pd);
      rl += int'(leaf_out & ~pl);
      gm += int'(global_out !== pc);
      {pd, pl, pc} = {div_out, leaf_out, clk_in};
    end
  endtask : measure

  // wait on a level of div_out, counting cycles; the bound keeps a stuck output from hanging
  task wait_div(input logic v);
    n = 0;
    while (div_out !== v && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
  endtask : wait_div

  initial forever #20 clk_sys = ~clk_sys;

  initial begin
    repeat (30000) @(posedge clk_sys);
    errors++;
    print_verdict();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    chk("div held", 0, div_out);
    wb(1'b0, CTRL_OFS, '0);
    chk("ctrl reset", 0, q);
    wb(1'b1, 4'h8, 32'h7);
    wb(1'b0, 4'h8, '0);
    chk("unmapped", 0, q);
    for (k = 0; k < 8; k++) begin
      clr_cmd <= 1'b1;
      wb(1'b1, CTRL_OFS, rows[k][0]);
      clr_cmd <= 1'b0;
      repeat (8) @(posedge clk_sys);
      measure(1680);
      chk("div high", rows[k][1], hd);
      chk("div rises", rows[k][2], rd);
      chk("leaf rises", rows[k][3], rl);
      chk("global", 0, gm);
    end
    // factor eight left in place: release, first rise, four input cycles high
    clr_cmd <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk("cleared", 0, div_out);
    clr_cmd <= 1'b0;
    wait_div(1'b1);
    chk("rise delay", 1, n <= 6);
    wait_div(1'b0);
    chk("first high", 8, n);
    wait_div(1'b1);
    repeat (4) @(posedge clk_sys);
    en_cmd <= 1'b0;
    repeat (20) @(posedge clk_sys);
    chk("frozen", 1, div_out);
    en_cmd <= 1'b1;
    wait_div(1'b0);
    chk("resume", 1, n >= 2 && n <= 8);
    // clear while high drops the output before the next sampling edge
    wb(1'b1, CTRL_OFS, 32'h0000_0407);
    wait_div(1'b1);
    clr_cmd <= 1'b1;
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk("clear async", 0, {leaf_out, div_out});
    // hard mode, factor one: count cycles the output keeps toggling after enable drops
    wb(1'b1, CTRL_OFS, 32'h0000_0100);
    clr_cmd <= 1'b0;
    repeat (10) @(posedge clk_sys);
    en_cmd <= 1'b0;
    t = 0;
    pd = div_out;
    for (n = 1; n < 14; n++) begin
      @(posedge clk_sys);
      if (div_out !== pd) t = n;
      pd = div_out;
    end
    chk("hard latency", 1, t >= 3 && t <= 6);
    // enable back: model register, three stages, output register, maybe one input phase
    en_cmd <= 1'b1;
    t = 0;
    pd = div_out;
    for (n = 1; n < 14; n++) begin
      @(posedge clk_sys);
      if (div_out !== pd && t == 0) t = n;
      pd = div_out;
    end
    chk("hard resume", 1, t >= 5 && t <= 7);
    // mid-run reset restores the defaults
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    chk("div reset", 0, div_out);
    wb(1'b0, CTRL_OFS, '0);
    chk("ctrl re-reset", 0, q);
    print_verdict();
  end
endmodule : gcd_clock_divider_tb

`default_nettype wire
